// ### core/sdm_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the six-channel deserializer
// Assumes: Included by bare name; definitions only
// Notes: Times are in ns; cycle counts derive from the 100 ns clock period
`ifndef SDM_CFG_SVH
`define SDM_CFG_SVH

`define SDM_CTRL_OFS 12'h000
`define SDM_STAT_OFS 12'h004
`define SDM_CTRL_SLEEPN_BIT 0
`define SDM_CTRL_OUTEN_BIT 1
`define SDM_CTRL_SEL_LSB 2
`define SDM_SLEEPN_RST 1'b0
`define SDM_OUTEN_RST 1'b0
`define SDM_SEL_RST 3'h6
`define SDM_RESP_OKAY 2'h0
`define SDM_RESP_SLVERR 2'h2

`define SDM_SEL_TEST_OFF 3'h6
`define SDM_SEL_TEST_SPARE 3'h7
`define SDM_FRAME_BITS 12
`define SDM_WORD_BITS 10
`define SDM_RCLK_FALL_IDX 6
`define SDM_MISS_LIMIT 2

`define SDM_CLK_NS 100
`define SDM_SYNC_CYCLES 80
`define SDM_LOCK_PD_NS 10000
`define SDM_LOCK_SYNC_NS 5000
`define SDM_LOCK_PD_CYC (`SDM_LOCK_PD_NS / `SDM_CLK_NS)
`define SDM_LOCK_SYNC_CYC (`SDM_LOCK_SYNC_NS / `SDM_CLK_NS)

`endif

// ### core/sdm_pkg.sv
// Purpose: Types shared by the six-channel deserializer
// Assumes: Nothing is imported; users write sdm_pkg::name
// Notes: Channel states are one-hot
package sdm_pkg;

  typedef enum logic [3:0] {
    ST_DOWN = 4'h1,
    ST_HUNT = 4'h2,
    ST_TRAIN = 4'h4,
    ST_LOCK = 4'h8
  } sdm_chan_e;

  typedef logic [1:0] sdm_resp_t;

endpackage

// ### core/sdm_pin_sync.sv
// Purpose: Three-stage synchroniser for pins from outside the clock domain
// Assumes: One clock, asynchronous active-high reset
// Notes: Output moves only when stages two and three agree
`timescale 1ns/100ps

module sdm_pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock, // System clock
  input wire logic reset, // Asynchronous reset, active high
  input wire logic [WIDTH-1:0] din, // Raw pin levels
  output logic [WIDTH-1:0] dout // Filtered, synchronised levels
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_dout;

  // Stage one feeds stage two only; a bit counts once two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_dout[i] = (stage2[i] == stage3[i]) ? stage3[i] : dout[i];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      dout <= next_dout;
    end
  end

endmodule // sdm_pin_sync

// ### core/sdm_top.sv
// Purpose: Six independent 1:10 deserializer channels with a spare input and test output
// Assumes: 10 MHz clock acts as reference; link bit clock and serial pins are asynchronous
// Notes: Control and lock status are reached over AXI4-Lite; tristate pins are value plus enable
// Function
// (R1) Lock after wake within bounded time
// (R2) Lock quickly once sync patterns arrive
// (R3) Select code routes spare or test pin
// (R4) Displaced input goes raw to test pin
// (R5) Sleep stops channels, floats every output
// (R6) Output disable floats words, clocks, test pin
// (R7) Unlocked channel floats words and clock
// (R8) Lock flag low means locked
// (R9) Find rising edge, synchronise after 80 cycles
// (R10) Lock flag falls with first valid word
// (R11) Frame: high start, ten data, low stop
// (R12) Serializer sends twelve bits per word
// (R13) Source word clock stays 20-40 MHz; the serializer model sends one 12-bit word every 9600 ns
// (R14) Recovered clock accompanies valid words
// (R15) Two missed edges drop lock, rehunt
// (R16) System watches lock, requests sync patterns
// (R17) Waking re-enters initialisation before data
// (R18) Six channels run independently
// (R19) Recovered clock toggles only when locked
// (R20) Reference clock must keep running
// (R21) Reference period near word-clock period; the reference instead samples the bit clock, 96 periods per bench word
// (R22) Per-channel state machine, reset by sleep
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "sdm_cfg.svh"

module sdm_top #(
  parameter int CHANNELS = 6,
  parameter int ADDR_W = 12
) (
  input wire logic clock, // 10 MHz reference clock
  input wire logic reset, // Asynchronous reset, active high
  input wire logic linkBitClock, // Serial bit clock from the link
  input wire logic [CHANNELS-1:0] serialInput, // Serial data, one per channel
  input wire logic spareSerialInput, // Spare serial input
  output logic [CHANNELS-1:0][9:0] wordOut, // Deserialised words
  output logic [CHANNELS-1:0] wordOe, // Word output enables
  output logic [CHANNELS-1:0] recoveredClock, // Recovered word clocks
  output logic [CHANNELS-1:0] recoveredClockOe, // Recovered clock enables
  output logic [CHANNELS-1:0] linkLockedN, // Lock flags, low when locked
  output logic [CHANNELS-1:0] linkLockedOe, // Lock flag enables
  output logic channelTestOut, // Raw displaced serial stream, or the spare stream under code 7
  output logic channelTestOe, // Test pin enable
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);

  localparam logic [3:0] LAST_IDX = 4'(`SDM_FRAME_BITS - 1);
  localparam logic [3:0] WORD_IDX = 4'(`SDM_WORD_BITS);
  localparam logic [3:0] FALL_IDX = 4'(`SDM_RCLK_FALL_IDX);
  localparam logic [7:0] SYNC_LAST = 8'(`SDM_SYNC_CYCLES - 1);
  localparam logic [7:0] TRAIN_LIMIT = 8'(`SDM_LOCK_PD_CYC);
  localparam logic [1:0] MISS_LAST = 2'(`SDM_MISS_LIMIT - 1);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Register decode shared by read and write paths

  function automatic logic [1:0] regIndex(input logic [ADDR_W-1:0] addr);
    if (addr == ADDR_W'(`SDM_CTRL_OFS)) begin
      return 2'h0;
    end else if (addr == ADDR_W'(`SDM_STAT_OFS)) begin
      return 2'h1;
    end
    return 2'h2;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and link bit strobe

  logic [CHANNELS+1:0] syncPins;
  logic prevLinkClock;
  logic linkRise;
  logic [CHANNELS-1:0] syncSerial;
  logic syncSpare;
  logic [CHANNELS-1:0] chIn;

  sdm_pin_sync #(
    .WIDTH(CHANNELS + 2)
  ) u_pin_sync (
    .clock(clock),
    .reset(reset),
    .din({linkBitClock, spareSerialInput, serialInput}),
    .dout(syncPins)
  );

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prevLinkClock <= 1'b0;
    end else begin
      prevLinkClock <= syncPins[CHANNELS+1];
    end
  end

  logic sleepRequestN;
  logic outputEnable;
  logic [2:0] spareRouteSelect;

  // The spare replaces the selected channel's input; codes 6 and 7 leave all channels alone
  always_comb begin
    syncSerial = syncPins[CHANNELS-1:0];
    syncSpare = syncPins[CHANNELS];
    linkRise = syncPins[CHANNELS+1] & ~prevLinkClock;
    for (int i = 0; i < CHANNELS; i++) begin
      chIn[i] = (spareRouteSelect == 3'(i)) ? syncSpare : syncSerial[i]; // R3 R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Channel state machines

  sdm_pkg::sdm_chan_e chState [CHANNELS];
  sdm_pkg::sdm_chan_e next_chState [CHANNELS];
  logic [3:0] bitIdx [CHANNELS];
  logic [3:0] next_bitIdx [CHANNELS];
  logic [9:0] shift [CHANNELS];
  logic [9:0] next_shift [CHANNELS];
  logic [CHANNELS-1:0] prevBit;
  logic [CHANNELS-1:0] next_prevBit;
  logic [1:0] missCnt [CHANNELS];
  logic [1:0] next_missCnt [CHANNELS];
  logic [7:0] trainCnt [CHANNELS];
  logic [7:0] next_trainCnt [CHANNELS];
  logic [CHANNELS-1:0][9:0] next_wordOut;
  logic [CHANNELS-1:0] next_recoveredClock;
  logic [CHANNELS-1:0] next_linkLockedN;

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      next_chState[i] = chState[i];
      next_bitIdx[i] = bitIdx[i];
      next_shift[i] = shift[i];
      next_prevBit[i] = prevBit[i];
      next_missCnt[i] = missCnt[i];
      next_trainCnt[i] = trainCnt[i];
      next_wordOut[i] = wordOut[i];
      next_recoveredClock[i] = recoveredClock[i];
      next_linkLockedN[i] = linkLockedN[i];
      if (!sleepRequestN) begin
        next_chState[i] = sdm_pkg::ST_DOWN; // R5 R22
        next_linkLockedN[i] = 1'b1;
        next_recoveredClock[i] = 1'b0;
      end else begin
        if (linkRise) begin
          next_prevBit[i] = chIn[i];
        end
        case (chState[i])
          sdm_pkg::ST_DOWN: begin
            next_chState[i] = sdm_pkg::ST_HUNT; // R17
          end
          sdm_pkg::ST_HUNT: begin
            // Any low-to-high step is taken as a stop-to-start edge; a wrong guess rehunts
            if (linkRise && !prevBit[i] && chIn[i]) begin
              next_chState[i] = sdm_pkg::ST_TRAIN; // R9 R2
              next_bitIdx[i] = 4'h1;
              next_trainCnt[i] = 8'h00;
              next_missCnt[i] = 2'h0;
            end
          end
          sdm_pkg::ST_TRAIN, sdm_pkg::ST_LOCK: begin
            if (chState[i] == sdm_pkg::ST_TRAIN && trainCnt[i] != TRAIN_LIMIT) begin
              next_trainCnt[i] = 8'(trainCnt[i] + 8'h01);
            end
            if (chState[i] == sdm_pkg::ST_TRAIN && trainCnt[i] == TRAIN_LIMIT) begin
              next_chState[i] = sdm_pkg::ST_HUNT; // R1
            end else if (linkRise && bitIdx[i] == 4'h0) begin
              next_bitIdx[i] = 4'h1;
              // Stop bit low then start bit high is the embedded clock edge
              if (!prevBit[i] && chIn[i]) begin // R11
                next_missCnt[i] = 2'h0;
                if (chState[i] == sdm_pkg::ST_LOCK || trainCnt[i] >= SYNC_LAST) begin
                  next_chState[i] = sdm_pkg::ST_LOCK; // R9
                  next_wordOut[i] = shift[i]; // R10 R14
                  next_linkLockedN[i] = 1'b0; // R8 R10
                  next_recoveredClock[i] = 1'b1; // R14 R19
                end
              end else if (chState[i] == sdm_pkg::ST_TRAIN || missCnt[i] == MISS_LAST) begin
                next_chState[i] = sdm_pkg::ST_HUNT; // R15
                next_linkLockedN[i] = 1'b1; // R8 R15
                next_recoveredClock[i] = 1'b0;
              end else begin
                next_missCnt[i] = 2'(missCnt[i] + 2'h1); // R15
              end
            end else if (linkRise) begin
              if (bitIdx[i] <= WORD_IDX) begin
                next_shift[i] = {chIn[i], shift[i][9:1]}; // R11
              end
              if (bitIdx[i] == FALL_IDX) begin
                next_recoveredClock[i] = 1'b0; // R14
              end
              next_bitIdx[i] = (bitIdx[i] == LAST_IDX) ? 4'h0 : 4'(bitIdx[i] + 4'h1);
            end
          end
          default: begin
            next_chState[i] = sdm_pkg::ST_DOWN;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < CHANNELS; i++) begin
        chState[i] <= sdm_pkg::ST_DOWN;
        bitIdx[i] <= 4'h0;
        shift[i] <= 10'h000;
        missCnt[i] <= 2'h0;
        trainCnt[i] <= 8'h00;
      end
      prevBit <= '0;
      wordOut <= '0;
      recoveredClock <= '0;
      linkLockedN <= '1;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin // R18
        chState[i] <= next_chState[i];
        bitIdx[i] <= next_bitIdx[i];
        shift[i] <= next_shift[i];
        missCnt[i] <= next_missCnt[i];
        trainCnt[i] <= next_trainCnt[i];
      end
      prevBit <= next_prevBit;
      wordOut <= next_wordOut;
      recoveredClock <= next_recoveredClock;
      linkLockedN <= next_linkLockedN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Output enables and channel test pin

  logic [CHANNELS-1:0] next_wordOe;
  logic [CHANNELS-1:0] next_linkLockedOe;
  logic next_channelTestOut;
  logic next_channelTestOe;

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      next_wordOe[i] = sleepRequestN & outputEnable & ~next_linkLockedN[i]; // R5 R6 R7
      next_linkLockedOe[i] = sleepRequestN; // R5 R6
    end
    next_channelTestOut = syncSpare; // R3
    for (int i = 0; i < CHANNELS; i++) begin
      if (spareRouteSelect == 3'(i)) begin
        next_channelTestOut = syncSerial[i]; // R4
      end
    end
    next_channelTestOe = sleepRequestN & outputEnable
      & (spareRouteSelect != `SDM_SEL_TEST_OFF); // R3 R5 R6
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wordOe <= '0;
      recoveredClockOe <= '0;
      linkLockedOe <= '0;
      channelTestOut <= 1'b0;
      channelTestOe <= 1'b0;
    end else begin
      wordOe <= next_wordOe;
      recoveredClockOe <= next_wordOe;
      linkLockedOe <= next_linkLockedOe;
      channelTestOut <= next_channelTestOut;
      channelTestOe <= next_channelTestOe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: control and lock status

  logic next_awready;
  logic next_arready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [1:0] next_rresp;
  logic [31:0] next_rdata;
  logic next_sleepRequestN;
  logic next_outputEnable;
  logic [2:0] next_spareRouteSelect;

  // Ready pulses one cycle after both write channels are offered, so no skid buffer is needed
  always_comb begin
    next_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
    next_arready = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    next_sleepRequestN = sleepRequestN;
    next_outputEnable = outputEnable;
    next_spareRouteSelect = spareRouteSelect;
    if (s_axi_awready) begin
      next_bvalid = 1'b1;
      next_bresp = (regIndex(s_axi_awaddr) == 2'h2) ? `SDM_RESP_SLVERR : `SDM_RESP_OKAY;
      if (regIndex(s_axi_awaddr) == 2'h0 && s_axi_wstrb[0]) begin
        next_sleepRequestN = s_axi_wdata[`SDM_CTRL_SLEEPN_BIT];
        next_outputEnable = s_axi_wdata[`SDM_CTRL_OUTEN_BIT];
        next_spareRouteSelect = s_axi_wdata[`SDM_CTRL_SEL_LSB +: 3];
      end
    end
    if (s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = `SDM_RESP_OKAY;
      next_rdata = 32'h0000_0000;
      case (regIndex(s_axi_araddr))
        2'h0: begin
          next_rdata[`SDM_CTRL_SLEEPN_BIT] = sleepRequestN;
          next_rdata[`SDM_CTRL_OUTEN_BIT] = outputEnable;
          next_rdata[`SDM_CTRL_SEL_LSB +: 3] = spareRouteSelect;
        end
        2'h1: begin
          next_rdata[CHANNELS-1:0] = ~linkLockedN;
        end
        default: begin
          next_rresp = `SDM_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SDM_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `SDM_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      sleepRequestN <= `SDM_SLEEPN_RST;
      outputEnable <= `SDM_OUTEN_RST;
      spareRouteSelect <= `SDM_SEL_RST;
    end else begin
      s_axi_awready <= next_awready;
      s_axi_wready <= next_awready;
      s_axi_arready <= next_arready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      sleepRequestN <= next_sleepRequestN;
      outputEnable <= next_outputEnable;
      spareRouteSelect <= next_spareRouteSelect;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sleep_floats_all_a: assert property ( // R5
    !sleepRequestN |=> (wordOe == '0) && (recoveredClockOe == '0) && (linkLockedOe == '0)
      && !channelTestOe && (linkLockedN == '1))
    else $error("sleep did not float outputs");

  disable_keeps_lock_a: assert property ( // R6
    sleepRequestN && !outputEnable |=> (wordOe == '0) && (recoveredClockOe == '0)
      && !channelTestOe && (linkLockedOe == '1))
    else $error("output disable misbehaved");

  unlocked_float_a: assert property ( // R7
    ((wordOe | recoveredClockOe) & linkLockedN) == '0)
    else $error("unlocked channel drives words");

  test_pin_off_a: assert property ( // R3
    spareRouteSelect == `SDM_SEL_TEST_OFF |=> !channelTestOe)
    else $error("test pin driven under code six");

  test_pin_raw_a: assert property ( // R4
    sleepRequestN && outputEnable && spareRouteSelect < `SDM_SEL_TEST_OFF
      |=> channelTestOe && channelTestOut == $past(syncSerial[spareRouteSelect]))
    else $error("displaced input not on test pin");

  for (genvar g = 0; g < CHANNELS; g++) begin : gChk
    logic startMiss;
    assign startMiss = linkRise && bitIdx[g] == 4'h0 && !(!prevBit[g] && chIn[g]);

    sequence firstMiss;
      chState[g] == sdm_pkg::ST_LOCK && startMiss && missCnt[g] == 2'h0;
    endsequence
    sequence secondMiss;
      chState[g] == sdm_pkg::ST_LOCK && startMiss && missCnt[g] == MISS_LAST;
    endsequence
    sequence lockEntry;
      chState[g] == sdm_pkg::ST_TRAIN ##1 chState[g] == sdm_pkg::ST_LOCK;
    endsequence

    one_miss_holds_a: assert property ( // R15
      sleepRequestN and firstMiss |=> !linkLockedN[g] && missCnt[g] == 2'h1)
      else $error("single miss dropped lock");

    two_miss_unlock_a: assert property ( // R15
      sleepRequestN and secondMiss |=> linkLockedN[g] && chState[g] == sdm_pkg::ST_HUNT)
      else $error("second miss kept lock");

    lock_with_data_a: assert property ( // R10
      lockEntry |-> !linkLockedN[g] && recoveredClock[g] && wordOut[g] == $past(shift[g])
        && $past(trainCnt[g]) >= SYNC_LAST)
      else $error("lock not with first word");

    rclk_when_locked_a: assert property ( // R19
      linkLockedN[g] |-> !recoveredClock[g])
      else $error("recovered clock while unlocked");
  end

endmodule // sdm_top

// ### verification/sdm_serializer_model.sv
// Purpose: Remote serializer sending framed words on six lanes plus the spare
// Assumes: The bit clock stands still while run is low
// Notes: Lanes change with the bit clock fall, so the receiver samples mid-bit
`timescale 1ns/100ps

module sdm_serializer_model (
  input wire logic run, // Send frames while high
  input wire logic [6:0] syncReq, // Per lane: send the sync word
  input wire logic [6:0] dropEdge, // Per lane: send a low start bit
  input wire logic [6:0][9:0] words, // Payload per lane
  output logic bitClock, // Serial bit clock
  output logic [6:0] lanes, // Serial lanes, spare is lane 6
  output int frames // Frames sent, bumps at the stop bit
);
  // One rising step per frame, so hunting cannot pick a false edge
  localparam logic [9:0] SYNC_WORD = 10'h000;
  logic [6:0][9:0] cur;
  logic [6:0] drop;

  initial begin
    bitClock = 1'b0;
    lanes = 7'h00;
    frames = 0;
    // Start 30 ns after a clock edge so no pin changes on a sampling edge
    wait (run);
    #30;
    forever begin
      wait (run);
      for (int c = 0; c < 7; c++) begin
        cur[c] = syncReq[c] ? SYNC_WORD : words[c];
      end
      drop = dropEdge;
      for (int b = 0; b < 12; b++) begin
        for (int c = 0; c < 7; c++) begin
          lanes[c] = (b == 0) ? !drop[c] : (b == 11) ? 1'b0 : cur[c][b-1];
        end
        if (b == 11) frames++;
        #400 bitClock = 1'b1;
        #400 bitClock = 1'b0;
      end
    end
  end
endmodule // sdm_serializer_model

// ### verification/sdm_top_tb.sv
// Purpose: Self-checking bench for the six-channel deserializer
// Assumes: Control register at 0x000, status at 0x004
// Notes: Lock flags feed the serializer sync requests
`timescale 1ns/100ps

module sdm_top_tb;
  logic clock, reset, run, tOut, tOe;
  logic bitClk, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [6:0] lanes, dropEdge, syncReq;
  logic [6:0][9:0] words;
  logic [5:0][9:0] wOut;
  logic [5:0] wOe, rClk, rOe, link_locked_n, lockOe, rHi, rLo;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd, rdat;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] sel;
  logic [15:0] lfsr;
  int frames, n_fail, tests_run;

  assign syncReq = {(sel < 3'h6) ? link_locked_n[sel] : 1'b1, link_locked_n};

  sdm_top i_sdm_top (.clock(clock), .reset(reset), .linkBitClock(bitClk),
    .serialInput(lanes[5:0]), .spareSerialInput(lanes[6]), .wordOut(wOut), .wordOe(wOe),
    .recoveredClock(rClk), .recoveredClockOe(rOe), .linkLockedN(link_locked_n),
    .linkLockedOe(lockOe), .channelTestOut(tOut), .channelTestOe(tOe),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr));

  sdm_serializer_model i_sdm_serializer_model (.run(run), .syncReq(syncReq),
    .dropEdge(dropEdge), .words(words), .bitClock(bitClk), .lanes(lanes), .frames(frames));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    r = bresp;
    br <= 1'b0;
    check("write answer", 32'(n), 32'h3);
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rdat;
    r = rresp;
    rr <= 1'b0;
    check("read answer", 32'(n), 32'h3);
  endtask

  // Lock needs up to a frame to find the edge, then the training span
  task automatic wait_lock(input logic [5:0] m, input int lim);
    int n;
    n = 0;
    while ((link_locked_n & m) !== 6'h00 && n < lim) begin
      @(posedge clock);
      n++;
    end
    check("lock time", 32'(link_locked_n & m), 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    #3000000;
    n_fail++;
    complete_run;
  end

  initial begin
    {reset, run, awv, wv, br, arv, rr, awa, ara, wd, sel} = {2'b10, 5'h00, 24'h0, 32'h0, 3'h6};
    {dropEdge, n_fail, tests_run, lfsr} = {7'h00, 64'h0, 16'h0047};
    for (int c = 0; c < 7; c++) begin
      lfsr = lfsr_next(lfsr);
      words[c] = (c == 0) ? 10'h3FF : lfsr[9:0];
    end
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    axi_rd(12'h000, rd, resp);
    check("ctrl reset", rd, 32'h18);
    axi_rd(12'h010, rd, resp);
    check("unmapped read", {rd[29:0], resp}, 32'h2);
    axi_wr(12'h020, 32'h0, resp);
    check("unmapped write", 32'(resp), 32'h2);
    check("asleep enables", {wOe, rOe, lockOe, tOe}, 32'h0);
    run <= 1'b1;
    axi_wr(12'h000, 32'h1B, resp);
    wait_lock(6'h3F, 300);
    repeat (200) @(posedge clock);
    for (int c = 0; c < 6; c++) check("word", 32'(wOut[c]), 32'(words[c]));
    check("locked enables", {wOe, rOe, tOe}, 32'h1FFE);
    {rHi, rLo} = 12'h000;
    repeat (100) begin
      @(posedge clock);
      rHi |= rClk;
      rLo |= ~rClk;
    end
    check("rclk toggles", {rHi, rLo}, 32'hFFF);
    axi_wr(12'h000, 32'h19, resp);
    repeat (6) @(posedge clock);
    check("disabled", {wOe, rOe, tOe, lockOe, link_locked_n}, 32'hFC0);
    axi_rd(12'h004, rd, resp);
    check("status", rd, 32'h3F);
    axi_wr(12'h000, 32'h1B, resp);
    for (int k = 0; k < 5; k++) begin
      @(frames);
      dropEdge = (k % 2 == 0) ? 7'h01 : 7'h00;
    end
    check("single miss", 32'(link_locked_n), 32'h0);
    @(frames);
    @(frames);
    dropEdge = 7'h00;
    check("double miss", {rClk[0], rOe, wOe, link_locked_n}, 32'h3EF81);
    wait_lock(6'h01, 400);
    for (int s = 0; s < 8; s++) begin
      sel = 3'(s);
      axi_wr(12'h000, {27'h0, sel, 2'h3}, resp);
      if (s < 6) begin
        wait_lock(6'h3F, 400);
        repeat (200) @(posedge clock);
        check("spare word", 32'(wOut[s]), 32'(words[6]));
      end
      repeat (3) begin
        @(posedge bitClk);
        repeat (3) @(posedge clock);
        check("test pin", {tOe, tOe & tOut}, (s == 6) ? 0 : {1'b1, lanes[(s == 7) ? 6 : s]});
      end
    end
    axi_wr(12'h000, 32'h1E, resp);
    repeat (6) @(posedge clock);
    check("sleep", {rClk, wOe, rOe, lockOe, tOe, link_locked_n}, 32'h3F);
    axi_wr(12'h000, 32'h1F, resp);
    wait_lock(6'h3F, 300);
    complete_run;
  end
endmodule // sdm_top_tb
